// ---- core/serializer_control_register_bank.sv ----
/*
  Control and status register bank of the audio link serializer.
  Assumes a local bus slave and the control channel hand in decoded
  register accesses on CLK_IN; pins and status levels are asynchronous.
*/
`default_nettype none

module serializer_control_register_bank #(
  parameter logic [2:0] REVISION_FIELD = 3'h5 // arbitrary value
) (
  // clock and reset
  input wire logic CLK_IN,
  input wire logic RESET_N_IN,
  // local access port
  input wire logic LOC_WR_IN,
  input wire logic LOC_RD_IN,
  input wire logic [7:0] LOC_ADDR_IN,
  input wire logic [7:0] LOC_WDATA_IN,
  output logic [7:0] LOC_RDATA_OUT,
  output logic LOC_RVALID_OUT,
  // remote access port
  input wire logic REM_WR_IN,
  input wire logic REM_RD_IN,
  input wire logic [7:0] REM_ADDR_IN,
  input wire logic [7:0] REM_WDATA_IN,
  output logic [7:0] REM_RDATA_OUT,
  output logic REM_RVALID_OUT,
  // pins and link status levels
  input wire logic [6:0] ADDRESS_STRAP_PIN_IN,
  input wire logic RX_LOCK_IN,
  input wire logic SELF_TEST_CRC_ERR_IN,
  input wire logic SCK_VALID_IN,
  input wire logic LINK_PRESENT_IN,
  input wire logic [3:0] REMOTE_GPO_IN,
  // control channel events
  input wire logic CRC_ERROR_IN,
  input wire logic REMOTE_ID_VALID_IN,
  input wire logic [6:0] REMOTE_ID_IN,
  // pass-through address lookup
  input wire logic PT_QUERY_IN,
  input wire logic PT_WRITE_IN,
  input wire logic [6:0] PT_ADDR_IN,
  output logic PT_DONE_OUT,
  output logic PT_LOCAL_OUT,
  output logic PT_PASS_OUT,
  output logic PT_AUTOACK_OUT,
  output logic [6:0] PT_TARGET_OUT,
  // configuration outputs
  output logic [6:0] OWN_ADDR_OUT,
  output logic ANALOG_POWER_DOWN_OUT,
  output logic OUTPUT_DRIVE_SELECT_OUT,
  output logic VIO_AUTO_OUT,
  output logic VIO_3V3_OUT,
  output logic CRC_CHECK_EN_OUT,
  output logic PARITY_EN_OUT,
  output logic SAMPLE_EDGE_SELECT_OUT,
  output logic DIGITAL_RESET_OUT,
  // general outputs
  output logic [3:0] GENERAL_OUTPUTS_OUT,
  output logic [3:0] GENERAL_OUTPUTS_OE_OUT
);

  logic [6:0] strap_s1, strap_s2;
  logic [3:0] stat_s1, stat_s2, rgpo_s1, rgpo_s2;
  logic full_rst, rst, lrst, wr_en, wr_loc;
  logic [7:0] wr_addr, wr_data, own, pwr, next_pwr, cfg;
  logic [7:0] rid, ralias, sid, salias, gpo32, gpo10;
  logic [15:0] cnt, nibs;
  logic des_err, lock, link, crc_ev;

  function automatic logic hit(input logic en, input logic [7:0] a,
                               input logic [7:0] b);
    hit = en && (a == b);
  endfunction

  // synchronisers for pins and foreign levels
  always_ff @(posedge CLK_IN) begin
    strap_s1 <= ADDRESS_STRAP_PIN_IN;
    stat_s1 <= {RX_LOCK_IN, SELF_TEST_CRC_ERR_IN, SCK_VALID_IN,
                LINK_PRESENT_IN};
    rgpo_s1 <= REMOTE_GPO_IN;
    strap_s2 <= strap_s1;
    stat_s2 <= stat_s1;
    rgpo_s2 <= rgpo_s1;
  end

  assign lock = stat_s2[3];
  assign link = stat_s2[0];
  assign rst = !RESET_N_IN || full_rst;
  assign lrst = rst || DIGITAL_RESET_OUT;
  assign crc_ev = CRC_ERROR_IN && cfg[ser_regs_pkg::CFG_CRC_EN];

  // write arbitration, local port first
  always_comb begin
    wr_en = LOC_WR_IN || REM_WR_IN;
    wr_loc = LOC_WR_IN;
    wr_addr = LOC_WR_IN ? LOC_ADDR_IN : REM_ADDR_IN;
    wr_data = LOC_WR_IN ? LOC_WDATA_IN : REM_WDATA_IN;
  end

  // self-clearing resets
  always_ff @(posedge CLK_IN) begin
    if (!RESET_N_IN) begin
      full_rst <= 1'b0;
      DIGITAL_RESET_OUT <= 1'b0;
    end else begin
      full_rst <= hit(wr_en, wr_addr, ser_regs_pkg::ADDR_PWR) &&
                  wr_data[ser_regs_pkg::PWR_RST0];
      DIGITAL_RESET_OUT <= hit(wr_en, wr_addr, ser_regs_pkg::ADDR_PWR) &&
                           (wr_data[ser_regs_pkg::PWR_RST0] ||
                            wr_data[ser_regs_pkg::PWR_RST1]);
    end
  end

  // own address register
  always_ff @(posedge CLK_IN) begin
    if (rst) begin
      own <= ser_regs_pkg::RST_OWN;
    end else if (hit(wr_en, wr_addr, ser_regs_pkg::ADDR_OWN)) begin
      own <= wr_data;
    end
  end

  // power register; remote cannot touch analog power-down
  always_comb begin
    next_pwr = wr_data & ser_regs_pkg::MASK_PWR;
    if (!wr_loc) begin
      next_pwr[ser_regs_pkg::PWR_APD] = pwr[ser_regs_pkg::PWR_APD];
    end
  end

  always_ff @(posedge CLK_IN) begin
    if (rst) begin
      pwr <= ser_regs_pkg::RST_PWR;
    end else if (hit(wr_en, wr_addr, ser_regs_pkg::ADDR_PWR)) begin
      pwr <= next_pwr;
    end
  end

  // general configuration
  always_ff @(posedge CLK_IN) begin
    if (rst) begin
      cfg <= ser_regs_pkg::RST_CFG;
    end else if (hit(wr_en, wr_addr, ser_regs_pkg::ADDR_CFG)) begin
      cfg <= wr_data;
    end
  end

  // remote receiver address with autoload
  always_ff @(posedge CLK_IN) begin
    if (rst) begin
      rid <= ser_regs_pkg::RST_RID;
    end else if (hit(wr_en, wr_addr, ser_regs_pkg::ADDR_RID)) begin
      rid <= wr_data;
    end else if (REMOTE_ID_VALID_IN && lock &&
                 !rid[ser_regs_pkg::ADDR_LSB]) begin
      rid <= {REMOTE_ID_IN, rid[ser_regs_pkg::ADDR_LSB]};
    end
  end

  // alias and slave address registers
  always_ff @(posedge CLK_IN) begin
    if (rst) begin
      ralias <= ser_regs_pkg::RST_ALIAS;
      sid <= ser_regs_pkg::RST_ALIAS;
      salias <= ser_regs_pkg::RST_ALIAS;
    end else begin
      if (hit(wr_en, wr_addr, ser_regs_pkg::ADDR_RALIAS)) begin
        ralias <= wr_data & ser_regs_pkg::MASK_ADDR;
      end
      if (hit(wr_en, wr_addr, ser_regs_pkg::ADDR_SID)) begin
        sid <= wr_data & ser_regs_pkg::MASK_ADDR;
      end
      if (hit(wr_en, wr_addr, ser_regs_pkg::ADDR_SALIAS)) begin
        salias <= wr_data & ser_regs_pkg::MASK_ADDR;
      end
    end
  end

  // output pin configuration
  always_ff @(posedge CLK_IN) begin
    if (rst) begin
      gpo32 <= ser_regs_pkg::RST_GPO32;
      gpo10 <= ser_regs_pkg::RST_GPO10;
    end else begin
      if (hit(wr_en, wr_addr, ser_regs_pkg::ADDR_GPO32)) begin
        gpo32 <= wr_data;
      end
      if (hit(wr_en, wr_addr, ser_regs_pkg::ADDR_GPO10)) begin
        gpo10 <= wr_data;
      end
    end
  end

  // crc error counter, saturating
  always_ff @(posedge CLK_IN) begin
    if (rst || cfg[ser_regs_pkg::CFG_CRC_CLR]) begin
      cnt <= '0;
    end else if (crc_ev && cnt != ser_regs_pkg::CNT_MAX) begin
      cnt <= cnt + ser_regs_pkg::CNT_ONE;
    end
  end

  // remote error flag, set wins over clear
  always_ff @(posedge CLK_IN) begin
    if (lrst) begin
      des_err <= 1'b0;
    end else if (crc_ev) begin
      des_err <= 1'b1;
    end else if (!link || cfg[ser_regs_pkg::CFG_CRC_CLR]) begin
      des_err <= 1'b0;
    end
  end

  function automatic logic [7:0] rd(input logic [7:0] a);
    case (a)
      ser_regs_pkg::ADDR_OWN: rd = own;
      ser_regs_pkg::ADDR_PWR: rd = pwr;
      ser_regs_pkg::ADDR_CFG: rd = cfg;
      ser_regs_pkg::ADDR_RID: rd = rid;
      ser_regs_pkg::ADDR_RALIAS: rd = ralias;
      ser_regs_pkg::ADDR_SID: rd = sid;
      ser_regs_pkg::ADDR_SALIAS: rd = salias;
      ser_regs_pkg::ADDR_CNT_LO: rd = cnt[7:0];
      ser_regs_pkg::ADDR_CNT_HI: rd = cnt[15:8];
      ser_regs_pkg::ADDR_STAT:
        rd = {REVISION_FIELD, stat_s2[3:1], des_err, stat_s2[0]};
      ser_regs_pkg::ADDR_GPO32: rd = gpo32;
      ser_regs_pkg::ADDR_GPO10: rd = gpo10;
      default: rd = 8'h00;
    endcase
  endfunction

  // read answers, one cycle after the strobe
  always_ff @(posedge CLK_IN) begin
    if (rst) begin
      LOC_RDATA_OUT <= 8'h00;
      LOC_RVALID_OUT <= 1'b0;
      REM_RDATA_OUT <= 8'h00;
      REM_RVALID_OUT <= 1'b0;
    end else begin
      LOC_RVALID_OUT <= LOC_RD_IN;
      REM_RVALID_OUT <= REM_RD_IN;
      if (LOC_RD_IN) begin
        LOC_RDATA_OUT <= rd(LOC_ADDR_IN);
      end
      if (REM_RD_IN) begin
        REM_RDATA_OUT <= rd(REM_ADDR_IN);
      end
    end
  end

  // own address source
  always_ff @(posedge CLK_IN) begin
    if (rst) begin
      OWN_ADDR_OUT <= ser_regs_pkg::RST_OWN[7:1];
    end else begin
      OWN_ADDR_OUT <= own[ser_regs_pkg::ADDR_LSB] ? own[7:1] : strap_s2;
    end
  end

  // pass-through lookup
  always_ff @(posedge CLK_IN) begin
    if (lrst) begin
      PT_DONE_OUT <= 1'b0;
      PT_LOCAL_OUT <= 1'b0;
      PT_PASS_OUT <= 1'b0;
      PT_AUTOACK_OUT <= 1'b0;
      PT_TARGET_OUT <= '0;
    end else begin
      PT_DONE_OUT <= PT_QUERY_IN;
      PT_LOCAL_OUT <= 1'b0;
      PT_PASS_OUT <= 1'b0;
      PT_AUTOACK_OUT <= 1'b0;
      PT_TARGET_OUT <= '0;
      if (PT_QUERY_IN) begin
        if (PT_ADDR_IN == OWN_ADDR_OUT) begin
          PT_LOCAL_OUT <= 1'b1;
        end else if (cfg[ser_regs_pkg::CFG_PT_EN]) begin
          if (ralias[7:1] != '0 && rid[7:1] != '0 &&
              PT_ADDR_IN == ralias[7:1]) begin
            PT_PASS_OUT <= 1'b1;
            PT_TARGET_OUT <= rid[7:1];
            PT_AUTOACK_OUT <= PT_WRITE_IN &&
                              cfg[ser_regs_pkg::CFG_AUTOACK];
          end else if (salias[7:1] != '0 &&
                       PT_ADDR_IN == salias[7:1]) begin
            PT_PASS_OUT <= 1'b1;
            PT_TARGET_OUT <= sid[7:1];
            PT_AUTOACK_OUT <= PT_WRITE_IN &&
                              cfg[ser_regs_pkg::CFG_AUTOACK];
          end else if (cfg[ser_regs_pkg::CFG_PASSALL] &&
                       rid[7:1] != '0) begin
            PT_PASS_OUT <= 1'b1;
            PT_TARGET_OUT <= rid[7:1];
            PT_AUTOACK_OUT <= PT_WRITE_IN &&
                              cfg[ser_regs_pkg::CFG_AUTOACK];
          end
        end
      end
    end
  end

  // output pins, pin 3 down to 0
  assign nibs = {gpo32[3:0], gpo32[7:4], gpo10[3:0], gpo10[7:4]};

  always_ff @(posedge CLK_IN) begin
    if (lrst) begin
      GENERAL_OUTPUTS_OUT <= '0;
      GENERAL_OUTPUTS_OE_OUT <= '0;
    end else begin
      for (int i = 0; i < 4; i++) begin
        GENERAL_OUTPUTS_OE_OUT[i] <= nibs[4*i+ser_regs_pkg::GN_EN] &&
                                     !nibs[4*i+ser_regs_pkg::GN_DIR];
        if (nibs[4*i+ser_regs_pkg::GN_REM]) begin
          GENERAL_OUTPUTS_OUT[i] <= rgpo_s2[i];
        end else begin
          GENERAL_OUTPUTS_OUT[i] <= nibs[4*i+ser_regs_pkg::GN_VAL];
        end
      end
    end
  end

  // configuration outputs straight from register bits
  assign ANALOG_POWER_DOWN_OUT = pwr[ser_regs_pkg::PWR_APD];
  assign OUTPUT_DRIVE_SELECT_OUT = pwr[ser_regs_pkg::PWR_DRIVE];
  assign VIO_AUTO_OUT = pwr[ser_regs_pkg::PWR_VAUTO];
  assign VIO_3V3_OUT = pwr[ser_regs_pkg::PWR_V33];
  assign CRC_CHECK_EN_OUT = cfg[ser_regs_pkg::CFG_CRC_EN];
  assign PARITY_EN_OUT = cfg[ser_regs_pkg::CFG_PAR_EN];
  assign SAMPLE_EDGE_SELECT_OUT = cfg[ser_regs_pkg::CFG_EDGE];

  // checks
  default clocking cb @(posedge CLK_IN); endclocking
  default disable iff (!RESET_N_IN);

  a_local_read: assert property (
    LOC_RD_IN && !full_rst |=> LOC_RVALID_OUT &&
      LOC_RDATA_OUT == rd($past(LOC_ADDR_IN)))
    else $error("local read answer wrong");
  a_remote_write: assert property (
    REM_WR_IN && !LOC_WR_IN && REM_ADDR_IN == ser_regs_pkg::ADDR_CFG
    |=> full_rst || cfg == $past(REM_WDATA_IN))
    else $error("remote write lost");
  a_own_source: assert property (
    own[ser_regs_pkg::ADDR_LSB] && !full_rst
    |=> OWN_ADDR_OUT == $past(own[7:1]))
    else $error("own address source wrong");
  a_pd_remote_lock: assert property (
    REM_WR_IN && !LOC_WR_IN && !full_rst
    |=> $stable(ANALOG_POWER_DOWN_OUT))
    else $error("remote changed power-down");
  a_reset1_pulse: assert property (
    LOC_WR_IN && LOC_ADDR_IN == ser_regs_pkg::ADDR_PWR &&
    LOC_WDATA_IN[ser_regs_pkg::PWR_RST1] &&
    !LOC_WDATA_IN[ser_regs_pkg::PWR_RST0] |=> DIGITAL_RESET_OUT ##1
    (!DIGITAL_RESET_OUT && cfg == $past(cfg)))
    else $error("logic reset not self clearing");
  a_reset0_regs: assert property (
    LOC_WR_IN && LOC_ADDR_IN == ser_regs_pkg::ADDR_PWR &&
    LOC_WDATA_IN[ser_regs_pkg::PWR_RST0]
    |=> ##1 cfg == ser_regs_pkg::RST_CFG && !full_rst)
    else $error("full reset missed registers");
  a_counter_hold: assert property (
    cfg[ser_regs_pkg::CFG_CRC_CLR] |=> cnt == '0)
    else $error("counter not held clear");
  a_counter_step: assert property (
    crc_ev && !cfg[ser_regs_pkg::CFG_CRC_CLR] && cnt < 16'h00FF &&
    !full_rst |=> cnt == $past(cnt) + 16'h0001)
    else $error("counter did not step");
  a_pt_disabled: assert property (
    PT_QUERY_IN && !cfg[ser_regs_pkg::CFG_PT_EN] |=> !PT_PASS_OUT)
    else $error("pass-through while disabled");
  a_des_flag: assert property (
    crc_ev && !DIGITAL_RESET_OUT && !full_rst |=> des_err)
    else $error("error flag not set");
  a_pin_float: assert property (
    !nibs[ser_regs_pkg::GN_EN] && !DIGITAL_RESET_OUT
    |=> !GENERAL_OUTPUTS_OE_OUT[0])
    else $error("disabled pin driven");

  c_remote_load: cover property (REMOTE_ID_VALID_IN && lock);
  c_pass_hit: cover property (PT_PASS_OUT ##1 PT_QUERY_IN);
  c_crc_count: cover property (crc_ev ##1 crc_ev);
  c_both_write: cover property (LOC_WR_IN && REM_WR_IN);

endmodule

`default_nettype wire

// ---- core/ser_regs_pkg.sv ----
/*
  Register map constants for the serializer control register bank.
  Assumes an 8-bit register offset space reached from two access ports.
*/
// Function
// - every register reads from local port and remote channel; all but counter and status also write from both
// - own address in bits 7:1; bit 0 picks strap or register value
// - power-down bit 3 controls analog block; only local writes change it
// - reset bit 1 resets logic but keeps registers, then self-clears
// - reset bit 0 resets logic and all registers, then self-clears
// - power bit 6 selects high or low output drive
// - bit 5 enables supply auto-detect; else bit 4 picks 3.3V or 1.8V
// - config bit 7 enables back-channel CRC check, bit 6 forward parity
// - config bit 5 holds CRC counters cleared until software writes 0
// - bit 4 acknowledges remote writes at once; use only while locked
// - bit 3 passes all non-own addresses remapped to remote receiver
// - config bit 2 enables pass-through to the remote side
// - config bit 0 picks rising or falling sample edge
// - accesses to receiver alias are remapped to stored receiver address
// - receiver address autoloads on lock unless freeze bit 0 is set
// - zero receiver address or alias blocks remote receiver access
// - slave alias remaps to stored slave address; zero alias disables
// - 16-bit read-only CRC error counter, low 0x0A, high 0x0B
// - status shows lock, self-test CRC error, clock valid, link present
// - status bit 1 sets on CRC error, clears on link loss or clear bit
// - output drives local value if enabled, output, remote off
// - remote enabled output pin drives value received over the link
// - enable 0 floats the pin; direction 1 input, 0 output
`default_nettype none

package ser_regs_pkg;
  // offsets
  localparam logic [7:0] ADDR_OWN = 8'h00;
  localparam logic [7:0] ADDR_PWR = 8'h01;
  localparam logic [7:0] ADDR_CFG = 8'h03;
  localparam logic [7:0] ADDR_RID = 8'h06;
  localparam logic [7:0] ADDR_RALIAS = 8'h07;
  localparam logic [7:0] ADDR_SID = 8'h08;
  localparam logic [7:0] ADDR_SALIAS = 8'h09;
  localparam logic [7:0] ADDR_CNT_LO = 8'h0A;
  localparam logic [7:0] ADDR_CNT_HI = 8'h0B;
  localparam logic [7:0] ADDR_STAT = 8'h0C;
  localparam logic [7:0] ADDR_GPO32 = 8'h0D;
  localparam logic [7:0] ADDR_GPO10 = 8'h0E;
  // reset values
  localparam logic [7:0] RST_OWN = 8'hB0;
  localparam logic [7:0] RST_PWR = 8'h30;
  localparam logic [7:0] RST_CFG = 8'hC5;
  localparam logic [7:0] RST_RID = 8'h00;
  localparam logic [7:0] RST_ALIAS = 8'h00;
  localparam logic [7:0] RST_GPO32 = 8'h55;
  localparam logic [7:0] RST_GPO10 = 8'h35;
  // stored bits
  localparam logic [7:0] MASK_PWR = 8'h78;
  localparam logic [7:0] MASK_ADDR = 8'hFE;
  // power field bits
  localparam int PWR_DRIVE = 6;
  localparam int PWR_VAUTO = 5;
  localparam int PWR_V33 = 4;
  localparam int PWR_APD = 3;
  localparam int PWR_RST1 = 1;
  localparam int PWR_RST0 = 0;
  // config field bits
  localparam int CFG_CRC_EN = 7;
  localparam int CFG_PAR_EN = 6;
  localparam int CFG_CRC_CLR = 5;
  localparam int CFG_AUTOACK = 4;
  localparam int CFG_PASSALL = 3;
  localparam int CFG_PT_EN = 2;
  localparam int CFG_EDGE = 0;
  // address register low bit: source select or freeze
  localparam int ADDR_LSB = 0;
  // output pin nibble fields
  localparam int GN_VAL = 3;
  localparam int GN_REM = 2;
  localparam int GN_DIR = 1;
  localparam int GN_EN = 0;
  localparam logic [15:0] CNT_MAX = 16'hFFFF;
  localparam logic [15:0] CNT_ONE = 16'h0001;
endpackage

`default_nettype wire

// ---- tb/far_side_model.sv ----
/*
  Remote host model: drives the bank's remote access port over the
  control channel and raises channel events. Assumes the bank's clock.
*/
`default_nettype none

module far_side_model (
  // clock
  input wire logic clk_in,
  // remote access port
  output logic rem_wr_out,
  output logic rem_rd_out,
  output logic [7:0] rem_addr_out,
  output logic [7:0] rem_wdata_out,
  input wire logic [7:0] rem_rdata_in,
  input wire logic rem_rvalid_in,
  // channel events
  output logic crc_error_out,
  output logic id_valid_out,
  output logic [6:0] id_out
);
  timeunit 1ns;
  timeprecision 100ps;

  initial begin
    rem_wr_out = 1'b0;
    rem_rd_out = 1'b0;
    rem_addr_out = 8'h00;
    rem_wdata_out = 8'h00;
    crc_error_out = 1'b0;
    id_valid_out = 1'b0;
    id_out = 7'h00;
  end

  task automatic step;
    @(posedge clk_in);
    #1;
  endtask

  // released lines show inverted values
  task automatic rem_write(input logic [7:0] a, input logic [7:0] d);
    step;
    rem_wr_out = 1'b1;
    rem_addr_out = a;
    rem_wdata_out = d;
    step;
    rem_wr_out = 1'b0;
    rem_addr_out = ~a;
    rem_wdata_out = ~d;
  endtask

  task automatic rem_read(input logic [7:0] a, output logic [7:0] d,
                          output logic v);
    step;
    rem_rd_out = 1'b1;
    rem_addr_out = a;
    step;
    rem_rd_out = 1'b0;
    rem_addr_out = ~a;
    v = rem_rvalid_in;
    d = rem_rdata_in;
  endtask

  // one error per cycle high
  task automatic crc_burst(input int n);
    step;
    crc_error_out = 1'b1;
    repeat (n) @(posedge clk_in);
    #1;
    crc_error_out = 1'b0;
  endtask

  // remote receiver address from the back channel
  task automatic send_id(input logic [6:0] id);
    step;
    id_valid_out = 1'b1;
    id_out = id;
    step;
    id_valid_out = 1'b0;
    id_out = ~id;
  endtask
endmodule

`default_nettype wire

// ---- tb/serializer_control_register_bank_bench.sv ----
/*
  Self-checking bench for the serializer control register bank.
  Assumes the far-side model drives the remote port and channel events.
*/
`default_nettype none

`define CHK(got, exp) begin compares++; if ((got) !== (exp)) begin \
  error_cnt++; $display("BAD %0t got %h exp %h", $time, got, exp); end end

module serializer_control_register_bank_bench;
  timeunit 1ns;
  timeprecision 100ps;
  localparam logic [2:0] REV = 3'h2; // arbitrary value
  localparam logic [7:0] RST_TAB [16] = '{8'hB0, 8'h30, 8'h00, 8'hC5,
    8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
    8'h55, 8'h35, 8'h00};
  localparam logic [7:0] GPO_TAB [6] = '{8'h91, 8'h6E, 8'hD5, 8'hD9,
    8'h55, 8'h35};
  logic clk, reset_n, loc_wr, loc_rd, rem_wr, rem_rd, loc_rvalid, rem_rvalid;
  logic [7:0] loc_addr, loc_wdata, loc_rdata, rem_addr, rem_wdata, rem_rdata;
  logic [6:0] strap, rem_id, pt_addr, pt_target, own_addr;
  logic lock, self_err, sck_ok, link, crc_err, id_valid, pt_query, pt_write;
  logic pt_done, pt_local, pt_pass, pt_ack, dig_rst;
  logic apd, drive, vauto, v33, crc_en, par_en, edge_sel;
  logic [3:0] rgpo, gpo, gpo_oe;
  int error_cnt, compares;

  serializer_control_register_bank #(.REVISION_FIELD(REV)) dut (
    .CLK_IN(clk), .RESET_N_IN(reset_n),
    .LOC_WR_IN(loc_wr), .LOC_RD_IN(loc_rd), .LOC_ADDR_IN(loc_addr),
    .LOC_WDATA_IN(loc_wdata), .LOC_RDATA_OUT(loc_rdata),
    .LOC_RVALID_OUT(loc_rvalid),
    .REM_WR_IN(rem_wr), .REM_RD_IN(rem_rd), .REM_ADDR_IN(rem_addr),
    .REM_WDATA_IN(rem_wdata), .REM_RDATA_OUT(rem_rdata),
    .REM_RVALID_OUT(rem_rvalid),
    .ADDRESS_STRAP_PIN_IN(strap), .RX_LOCK_IN(lock),
    .SELF_TEST_CRC_ERR_IN(self_err), .SCK_VALID_IN(sck_ok),
    .LINK_PRESENT_IN(link), .REMOTE_GPO_IN(rgpo), .CRC_ERROR_IN(crc_err),
    .REMOTE_ID_VALID_IN(id_valid), .REMOTE_ID_IN(rem_id),
    .PT_QUERY_IN(pt_query), .PT_WRITE_IN(pt_write), .PT_ADDR_IN(pt_addr),
    .PT_DONE_OUT(pt_done), .PT_LOCAL_OUT(pt_local), .PT_PASS_OUT(pt_pass),
    .PT_AUTOACK_OUT(pt_ack), .PT_TARGET_OUT(pt_target),
    .OWN_ADDR_OUT(own_addr), .ANALOG_POWER_DOWN_OUT(apd),
    .OUTPUT_DRIVE_SELECT_OUT(drive), .VIO_AUTO_OUT(vauto),
    .VIO_3V3_OUT(v33), .CRC_CHECK_EN_OUT(crc_en), .PARITY_EN_OUT(par_en),
    .SAMPLE_EDGE_SELECT_OUT(edge_sel), .DIGITAL_RESET_OUT(dig_rst),
    .GENERAL_OUTPUTS_OUT(gpo), .GENERAL_OUTPUTS_OE_OUT(gpo_oe)
  );

  far_side_model far (
    .clk_in(clk), .rem_wr_out(rem_wr), .rem_rd_out(rem_rd),
    .rem_addr_out(rem_addr), .rem_wdata_out(rem_wdata),
    .rem_rdata_in(rem_rdata), .rem_rvalid_in(rem_rvalid),
    .crc_error_out(crc_err), .id_valid_out(id_valid), .id_out(rem_id)
  );

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  task automatic tick;
    @(posedge clk);
    #1;
  endtask

  task automatic loc_write(input logic [7:0] a, input logic [7:0] d);
    tick;
    loc_wr = 1'b1;
    loc_addr = a;
    loc_wdata = d;
    tick;
    loc_wr = 1'b0;
    loc_addr = ~a;
    loc_wdata = ~d;
  endtask

  // read on either port, then compare valid and data
  task automatic check_rd(input logic rem, input logic [7:0] a,
                          input logic [7:0] e);
    logic [7:0] d;
    logic v;
    if (rem) begin
      far.rem_read(a, d, v);
    end else begin
      tick;
      loc_rd = 1'b1;
      loc_addr = a;
      tick;
      loc_rd = 1'b0;
      loc_addr = ~a;
      v = loc_rvalid;
      d = loc_rdata;
    end
    `CHK(v, 1'b1)
    `CHK(d, e)
  endtask

  task automatic pt_check(input logic [7:0] c, input logic [6:0] a,
                          input logic w, input logic [2:0] e,
                          input logic [6:0] t);
    loc_write(8'h03, c);
    tick;
    pt_query = 1'b1;
    pt_addr = a;
    pt_write = w;
    tick;
    pt_query = 1'b0;
    pt_addr = ~a;
    `CHK(pt_done, 1'b1)
    `CHK({pt_local, pt_pass, pt_ack}, e)
    if (e[1]) `CHK(pt_target, t)
  endtask

  function automatic logic [7:0] stat(input logic derr);
    return {REV, lock, self_err, sck_ok, derr, link};
  endfunction

  // nibble {value, remote, direction, enable} per pin
  function automatic logic [7:0] gpo_exp(input logic [7:0] hi,
                                         input logic [7:0] lo);
    logic [15:0] n;
    logic [7:0] r;
    n = {hi[3:0], hi[7:4], lo[3:0], lo[7:4]};
    for (int p = 0; p < 4; p++) begin
      r[4 + p] = n[4 * p] & ~n[4 * p + 1];
      r[p] = n[4 * p + 2] ? rgpo[p] : n[4 * p + 3];
    end
    return r;
  endfunction

  task automatic done(input string name);
    $display("test %s finished", name);
  endtask

  task automatic stop_test;
    $display("comparisons %0d mismatches %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  initial begin
    repeat (6000) @(posedge clk);
    error_cnt++;
    stop_test;
  end

  initial begin
    {reset_n, loc_wr, loc_rd, loc_addr, loc_wdata} = '0;
    {lock, self_err, pt_query, pt_write, pt_addr} = '0;
    strap = 7'h2A;
    sck_ok = 1'b1;
    link = 1'b1;
    rgpo = 4'b1010;
    repeat (20) tick;
    reset_n = 1'b1;
    repeat (4) tick;
    for (int i = 0; i < 16; i++)
      check_rd(i[0], i[7:0], i == 12 ? stat(1'b0) : RST_TAB[i]);
    `CHK(own_addr, 7'h2A)
    `CHK({apd, drive, vauto, v33, crc_en, par_en, edge_sel}, 7'h1F)
    `CHK({gpo_oe, gpo}, gpo_exp(8'h55, 8'h35))
    strap = 7'h15;
    repeat (4) tick;
    `CHK(own_addr, 7'h15)
    strap = 7'h2A;
    done("reset");
    far.rem_write(8'h00, 8'h6B);
    check_rd(1'b0, 8'h00, 8'h6B);
    `CHK(own_addr, 7'h35)
    loc_write(8'h01, 8'h58);
    `CHK({apd, drive, vauto, v33, crc_en, par_en, edge_sel}, 7'h6F)
    far.rem_write(8'h01, 8'h20);
    check_rd(1'b0, 8'h01, 8'h28);
    `CHK({apd, drive, vauto, v33, crc_en, par_en, edge_sel}, 7'h57)
    far.rem_write(8'h03, 8'h42);
    `CHK({crc_en, par_en, edge_sel}, 3'b010)
    loc_write(8'h02, 8'hFF);
    far.rem_write(8'h0F, 8'hFF);
    loc_write(8'h0A, 8'hFF);
    loc_write(8'h07, 8'hFF);
    check_rd(1'b1, 8'h02, 8'h00);
    check_rd(1'b0, 8'h0F, 8'h00);
    check_rd(1'b1, 8'h0A, 8'h00);
    check_rd(1'b0, 8'h07, 8'hFE);
    done("access");
    loc_write(8'h03, 8'h80);
    far.crc_burst(258);
    check_rd(1'b0, 8'h0A, 8'h02);
    check_rd(1'b1, 8'h0B, 8'h01);
    check_rd(1'b0, 8'h0C, stat(1'b1));
    loc_write(8'h03, 8'h00);
    far.crc_burst(5);
    check_rd(1'b0, 8'h0A, 8'h02);
    loc_write(8'h03, 8'hA0);
    check_rd(1'b1, 8'h0C, stat(1'b0));
    far.crc_burst(3);
    check_rd(1'b0, 8'h0A, 8'h00);
    loc_write(8'h03, 8'h80);
    far.crc_burst(1);
    check_rd(1'b1, 8'h0A, 8'h01);
    link = 1'b0;
    repeat (5) tick;
    check_rd(1'b0, 8'h0C, stat(1'b0));
    link = 1'b1;
    done("counter");
    loc_write(8'h03, 8'h0C);
    loc_write(8'h01, 8'h32);
    for (int n = 0; n < 5 && dig_rst !== 1'b1; n++) tick;
    `CHK(dig_rst, 1'b1)
    tick;
    `CHK(dig_rst, 1'b0)
    check_rd(1'b0, 8'h03, 8'h0C);
    check_rd(1'b1, 8'h01, 8'h30);
    loc_write(8'h01, 8'h31);
    for (int n = 0; n < 5 && dig_rst !== 1'b1; n++) tick;
    `CHK(dig_rst, 1'b1)
    repeat (4) tick;
    check_rd(1'b0, 8'h03, ser_regs_pkg::RST_CFG);
    check_rd(1'b1, 8'h01, ser_regs_pkg::RST_PWR);
    check_rd(1'b0, 8'h0A, 8'h00);
    done("soft reset");
    lock = 1'b1;
    repeat (5) tick;
    loc_write(8'h06, 8'h40);
    far.send_id(7'h11);
    check_rd(1'b0, 8'h06, 8'h22);
    loc_write(8'h06, 8'h41);
    far.send_id(7'h12);
    check_rd(1'b1, 8'h06, 8'h41);
    loc_write(8'h06, 8'h40);
    loc_write(8'h07, 8'h44);
    loc_write(8'h08, 8'h50);
    loc_write(8'h09, 8'h52);
    pt_check(8'h04, 7'h2A, 1'b0, 3'b100, 7'h00);
    pt_check(8'h04, 7'h22, 1'b0, 3'b010, 7'h20);
    pt_check(8'h04, 7'h29, 1'b1, 3'b010, 7'h28);
    pt_check(8'h04, 7'h33, 1'b1, 3'b000, 7'h00);
    pt_check(8'h1C, 7'h33, 1'b1, 3'b011, 7'h20);
    pt_check(8'h1C, 7'h22, 1'b0, 3'b010, 7'h20);
    pt_check(8'h00, 7'h22, 1'b1, 3'b000, 7'h00);
    loc_write(8'h07, 8'h00);
    pt_check(8'h04, 7'h22, 1'b0, 3'b000, 7'h00);
    loc_write(8'h09, 8'h00);
    pt_check(8'h04, 7'h29, 1'b0, 3'b000, 7'h00);
    done("pass-through");
    for (int i = 0; i < 3; i++) begin
      rgpo = ~rgpo;
      loc_write(8'h0D, GPO_TAB[2 * i]);
      far.rem_write(8'h0E, GPO_TAB[2 * i + 1]);
      repeat (3) tick;
      `CHK({gpo_oe, gpo}, gpo_exp(GPO_TAB[2 * i], GPO_TAB[2 * i + 1]))
    end
    self_err = 1'b1;
    sck_ok = 1'b0;
    repeat (5) tick;
    check_rd(1'b1, 8'h0C, stat(1'b0));
    done("outputs and status");
    stop_test;
  end
endmodule

`default_nettype wire
